// File: rtl/mcw_top.sv
// Multi-turn coordinate manager with optional wrap.
// Assumes step and dir from same-clock motion logic and power
// sense levels and frame strap from pins.
//
// Overview of operation
// - Turn count past maximum restarts at zero
// - Maximum 900 turns small frames, else 1800
// - Settings sampled only at control power-up
// - Initial coordinate built at every power-up
// - Wrap presets coordinate leaving the range
// - Leaving range reverses the coordinate sign
// - Wrap preset never touches step counter
// - Step counter always counts motor steps
// - Step counter rolls over two's complement
// - Step counter readable at read-only index
// - Manual source value one enables settings
// - Source change needs both powers cycled
// - Range counts tenths of a revolution
// - Offset ratio counts hundredths of percent
// - Defaults split turns half each side
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "mcw_params.svh"
module mcw_top #(
  parameter int STEPS_PER_REV = 1000,  // Motor steps per output turn
  parameter int ADR_W         = 18     // Wishbone byte address width
) (
  input  wire logic             clk_i,          // 50 MHz
  input  wire logic             rst_i,          // Sync, active high
  input  wire logic             wb_cyc_i,       // Bus cycle
  input  wire logic             wb_stb_i,       // Bus strobe
  input  wire logic             wb_we_i,        // Write
  input  wire logic [ADR_W-1:0] wb_adr_i,       // Byte address
  input  wire logic [3:0]       wb_sel_i,       // Byte lanes
  input  wire logic [31:0]      wb_dat_i,       // Write data
  output logic      [31:0]      wb_dat_o,       // Read data
  output logic                  wb_ack_o,       // Answer
  input  wire logic             main_pwr_i,     // Main power sense pin
  input  wire logic             ctl_pwr_i,      // Control power sense pin
  input  wire logic             frame_small_i,  // Strap: small frame
  input  wire logic             step_i,         // One step pulse
  input  wire logic             dir_i,          // High: forward
  output logic      [31:0]      coord_o,        // Present coordinate
  output logic                  coord_valid_o,  // Coordinate generated
  output logic      [31:0]      step_count_o    // Raw step counter
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Step within a turn is held in 16 bits
  if (STEPS_PER_REV < 2 || STEPS_PER_REV > 65535) begin : g_chk
    $error("mcw_top: STEPS_PER_REV out of range");
  end
  localparam logic [15:0] SUB_LAST = 16'(STEPS_PER_REV - 1);
  localparam logic [31:0] SPR      = 32'(STEPS_PER_REV);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mcw_cfg_if cif ();                      // Register file carrier
  logic              ctl_meta_ff;        // Synchroniser stage one
  logic              ctl_s_ff;           // Control power, synced
  logic              ctl_prev_ff;        // For edge detect
  logic              main_meta_ff;       // Synchroniser stage one
  logic              main_s_ff;          // Main power, synced
  logic              frm_meta_ff;        // Synchroniser stage one
  logic              frm_s_ff;           // Frame strap, synced
  logic              both_off_ff;        // Both supplies seen off
  logic              manual_ff;          // Active coordinate source
  logic              wrap_act_ff;        // Active wrap enable
  logic [31:0]       range_act_ff;       // Active range, tenths
  logic [31:0]       ratio_act_ff;       // Active ratio, 0.01 %
  logic signed [31:0] ofs_act_ff;        // Active offset, steps
  logic [10:0]       turn_max_ff;        // Active turn maximum
  logic [10:0]       turn_ff;            // Stored turn count
  logic [15:0]       sub_ff;             // Step within the turn
  logic [31:0]       step_cnt_ff;        // Free-running counter
  logic signed [31:0] coord_ff;          // Wrapped coordinate
  mcw_pkg::mcw_state_e st_ff;            // Core state
  mcw_pkg::mcw_state_e nxt_st;           // Next core state
  logic signed [31:0] span_w;            // Window width
  logic signed [31:0] low_w;             // Window bottom
  logic signed [31:0] high_w;            // Window top, exclusive

  // ----------------------------------------------------------------
  // Register file and window arithmetic
  // ----------------------------------------------------------------
  mcw_wb_regs #(
    .ADR_W (ADR_W)
  ) u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cif      (cif.regs)
  );

  mcw_window #(
    .STEPS_PER_REV (STEPS_PER_REV)
  ) u_window (
    .range_i  (range_act_ff),
    .ratio_i  (ratio_act_ff),
    .offset_i (ofs_act_ff),
    .span_o   (span_w),
    .low_o    (low_w),
    .high_o   (high_w)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Power sense and strap come from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_meta_ff  <= 1'h0;
      ctl_s_ff     <= 1'h0;
      main_meta_ff <= 1'h0;
      main_s_ff    <= 1'h0;
      frm_meta_ff  <= 1'h0;
      frm_s_ff     <= 1'h0;
    end else begin
      ctl_meta_ff  <= ctl_pwr_i;
      ctl_s_ff     <= ctl_meta_ff;
      main_meta_ff <= main_pwr_i;
      main_s_ff    <= main_meta_ff;
      frm_meta_ff  <= frame_small_i;
      frm_s_ff     <= frm_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Power sequencing
  // ----------------------------------------------------------------
  // Edge detect reads the second stage only
  wire logic ctl_rise_w = ctl_s_ff & ~ctl_prev_ff;
  wire logic off_both_w = ~ctl_s_ff & ~main_s_ff;
  // Source follows the register only after a full power cycle
  wire logic src_reg_man_w = (cif.cfg.src == `MCW_SRC_MANUAL);
  wire logic sel_man_w = both_off_ff ? src_reg_man_w : manual_ff;
  // Turn total depends on motor frame size
  wire logic [10:0] turns_w = frm_s_ff ? `MCW_TURNS_SMALL : `MCW_TURNS_LARGE;
  // Factory split: whole turn total, half each side of home
  wire logic [31:0] def_range_w = {21'h0, turns_w} * `MCW_TENTHS_REV;

  // Track whether both supplies were removed since the last start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_prev_ff <= 1'h0;
      both_off_ff <= 1'h1;  // Reset stands for a cold start
    end else begin
      ctl_prev_ff <= ctl_s_ff;
      if (off_both_w) begin
        both_off_ff <= 1'h1;
      end else if (ctl_rise_w) begin
        both_off_ff <= 1'h0;
      end
    end
  end

  // Settings are frozen between control power-ups, so a write
  // while running cannot move the window under the motor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      manual_ff    <= 1'h0;
      wrap_act_ff  <= 1'h0;
      range_act_ff <= `MCW_RST_RANGE;
      ratio_act_ff <= `MCW_RATIO_HALF;
      ofs_act_ff   <= `MCW_RST_OFFSET;
      turn_max_ff  <= `MCW_TURNS_LARGE;
    end else if (ctl_rise_w) begin
      manual_ff    <= sel_man_w;
      turn_max_ff  <= turns_w;
      if (sel_man_w) begin
        wrap_act_ff  <= cif.cfg.wrap_en;
        range_act_ff <= cif.cfg.range;
        ratio_act_ff <= cif.cfg.ratio;
        ofs_act_ff   <= cif.cfg.offset;
      end else begin
        wrap_act_ff  <= 1'h0;
        range_act_ff <= def_range_w;
        ratio_act_ff <= `MCW_RATIO_HALF;
        ofs_act_ff   <= `MCW_RST_OFFSET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mechanical turn store
  // ----------------------------------------------------------------
  wire logic fwd_w = step_i & dir_i;
  wire logic rev_w = step_i & ~dir_i;
  wire logic turn_up_w = fwd_w & (sub_ff == SUB_LAST);
  wire logic turn_dn_w = rev_w & (sub_ff == 16'h0);

  // Keeps counting with control power off, like the sensor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      turn_ff <= 11'h0;
      sub_ff  <= 16'h0;
    end else begin
      if (turn_up_w) begin
        sub_ff  <= 16'h0;
        turn_ff <= (turn_ff >= turn_max_ff) ? 11'h0 : turn_ff + 11'h1;
      end else if (turn_dn_w) begin
        sub_ff  <= SUB_LAST;
        turn_ff <= (turn_ff == 11'h0) ? turn_max_ff : turn_ff - 11'h1;
      end else if (fwd_w) begin
        sub_ff  <= sub_ff + 16'h1;
      end else if (rev_w) begin
        sub_ff  <= sub_ff - 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Raw step counter
  // ----------------------------------------------------------------
  // One signed step per pulse; wraps naturally at 32 bits
  wire logic signed [31:0] delta_w = fwd_w ? 32'sh1 : (rev_w ? -32'sh1 : 32'sh0);

  // No preset input at all, so wrap can never disturb it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_cnt_ff <= 32'h0;
    end else begin
      step_cnt_ff <= step_cnt_ff + delta_w;
    end
  end

  // ----------------------------------------------------------------
  // Core state machine
  // ----------------------------------------------------------------
  wire logic in_calc_w = (st_ff == mcw_pkg::mcw_calc);
  wire logic in_run_w  = (st_ff == mcw_pkg::mcw_run);
  // Absolute position held by the turn store
  wire logic [31:0] abs_w = {21'h0, turn_ff} * SPR + {16'h0, sub_ff};
  // Coordinate after this cycle's step
  wire logic signed [31:0] sum_w = coord_ff + delta_w;
  wire logic over_w  = (sum_w >= high_w);
  wire logic under_w = (sum_w < low_w);
  // Generation folds every cycle, running only with wrap on
  wire logic fold_w = in_calc_w | (in_run_w & wrap_act_ff);
  wire logic calc_done_w = in_calc_w & ~over_w & ~under_w;

  // Next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      mcw_pkg::mcw_idle: begin
        if (ctl_rise_w) begin
          nxt_st = mcw_pkg::mcw_calc;
        end
      end
      mcw_pkg::mcw_calc: begin
        if (!ctl_s_ff) begin
          nxt_st = mcw_pkg::mcw_idle;
        end else if (calc_done_w) begin
          nxt_st = mcw_pkg::mcw_run;
        end
      end
      mcw_pkg::mcw_run: begin
        if (!ctl_s_ff) begin
          nxt_st = mcw_pkg::mcw_idle;
        end
      end
      default: begin
        nxt_st = mcw_pkg::mcw_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= mcw_pkg::mcw_idle;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Wrapped coordinate
  // ----------------------------------------------------------------
  // Generation subtracts or adds one span per cycle until the value lies
  // inside the window of one span width; a step at the edge lands on
  // the far end with the sign turned round
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coord_ff <= 32'sh0;
    end else if (ctl_rise_w) begin
      coord_ff <= $signed(abs_w);
    end else if (fold_w && over_w) begin
      coord_ff <= sum_w - span_w;
    end else if (fold_w && under_w) begin
      coord_ff <= sum_w + span_w;
    end else begin
      coord_ff <= sum_w;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and readback
  // ----------------------------------------------------------------
  assign cif.step_cnt  = step_cnt_ff;
  assign cif.coord     = coord_ff;
  assign cif.status    = {5'h0, turn_ff, 13'h0, manual_ff, wrap_act_ff, in_run_w};
  assign coord_o       = coord_ff;
  assign coord_valid_o = in_run_w;
  assign step_count_o  = step_cnt_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_turn_rollover: assert property (@(posedge clk_i) disable iff (rst_i)
    turn_up_w && (turn_ff == turn_max_ff) |=> (turn_ff == 11'h0) && (sub_ff == 16'h0))
    else $error("turn store did not restart at zero");

  a_turn_max_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_rise_w |=> turn_max_ff == (($past(frm_s_ff)) ? `MCW_TURNS_SMALL : `MCW_TURNS_LARGE))
    else $error("turn maximum does not match frame size");

  a_cfg_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_rise_w |=> $stable(range_act_ff) && $stable(ratio_act_ff) && $stable(wrap_act_ff))
    else $error("active settings changed without power-up");

  a_init_gen: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_rise_w ##1 ctl_s_ff |-> in_calc_w && (coord_ff == $signed($past(abs_w))))
    else $error("no initial coordinate generated at power-up");

  a_wrap_window: assert property (@(posedge clk_i) disable iff (rst_i)
    in_run_w && wrap_act_ff |-> (coord_ff >= low_w) && (coord_ff < high_w))
    else $error("wrapped coordinate outside window");

  a_sign_flip: assert property (@(posedge clk_i) disable iff (rst_i)
    in_run_w && wrap_act_ff && fwd_w && (coord_ff == high_w - 32'sh1) && !ctl_rise_w
    |=> coord_ff == $past(low_w))
    else $error("coordinate did not jump to far end");

  a_step_count: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 step_cnt_ff == $past(step_cnt_ff) + $past(delta_w))
    else $error("step counter moved wrongly");

  a_src_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_rise_w && !both_off_ff |=> manual_ff == $past(manual_ff))
    else $error("source changed without full power cycle");

endmodule : mcw_top

// File: rtl/mcw_wb_regs.sv
// Classic Wishbone slave holding the coordinate settings.
// Assumes a single-cycle master that holds the request until ack.
`timescale 1ns/100ps
`include "mcw_params.svh"
module mcw_wb_regs #(
  parameter int ADR_W = 18
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  mcw_cfg_if.regs          cif
);
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  if (ADR_W < 17) begin : g_chk
    $error("mcw_wb_regs: address too narrow for the map");
  end
  // Word address match
  function automatic logic hit(input logic [ADR_W-1:0] a, input logic [15:0] idx);
    hit = (a == ADR_W'({idx, 2'h0}));
  endfunction : hit
  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge
  logic              ack_ff;   // Answer one cycle after request
  logic [31:0]       dat_ff;   // Registered read data
  mcw_pkg::mcw_cfg_s cfg_ff;   // Settings, survive control power
  wire logic req_w = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire logic wr_w  = req_w & wb_we_i;
  // Read select, unmapped reads as zero
  wire logic [31:0] rd_w =
    hit(wb_adr_i, `MCW_IDX_WRAP_EN)  ? {31'h0, cfg_ff.wrap_en} :
    hit(wb_adr_i, `MCW_IDX_RANGE)    ? cfg_ff.range :
    hit(wb_adr_i, `MCW_IDX_RATIO)    ? cfg_ff.ratio :
    hit(wb_adr_i, `MCW_IDX_OFFSET)   ? cfg_ff.offset :
    hit(wb_adr_i, `MCW_IDX_SRC_SEL)  ? cfg_ff.src :
    hit(wb_adr_i, `MCW_IDX_STEP_CNT) ? cif.step_cnt :
    hit(wb_adr_i, `MCW_IDX_COORD)    ? cif.coord :
    hit(wb_adr_i, `MCW_IDX_STATUS)   ? cif.status : 32'h0;
  // Bus answer, the step counter index is never writable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'h0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= req_w;
      dat_ff <= req_w ? rd_w : dat_ff;
    end
  end
  // Setting writes; ignored on unmapped or read-only indices
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= '{`MCW_RST_WRAP_EN, `MCW_RST_RANGE, `MCW_RST_RATIO,
                 `MCW_RST_OFFSET, `MCW_RST_SRC};
    end else if (wr_w) begin
      if (hit(wb_adr_i, `MCW_IDX_WRAP_EN) && wb_sel_i[0]) cfg_ff.wrap_en <= wb_dat_i[0];
      if (hit(wb_adr_i, `MCW_IDX_RANGE))  cfg_ff.range  <= merge(cfg_ff.range, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, `MCW_IDX_RATIO))  cfg_ff.ratio  <= merge(cfg_ff.ratio, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, `MCW_IDX_OFFSET)) cfg_ff.offset <= merge(cfg_ff.offset, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, `MCW_IDX_SRC_SEL)) cfg_ff.src  <= merge(cfg_ff.src, wb_dat_i, wb_sel_i);
    end
  end
  assign cif.cfg  = cfg_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
endmodule : mcw_wb_regs

// File: rtl/mcw_window.sv
// Coordinate window arithmetic from the latched settings.
// Assumes stable inputs between control power-ups.
`timescale 1ns/100ps
`include "mcw_params.svh"
module mcw_window #(
  parameter int STEPS_PER_REV = 1000
) (
  input  wire logic        [31:0] range_i,  // Tenths of a revolution
  input  wire logic        [31:0] ratio_i,  // Hundredths of a percent
  input  wire logic signed [31:0] offset_i, // Steps
  output logic signed      [31:0] span_o,   // Window width in steps
  output logic signed      [31:0] low_o,    // First coordinate inside
  output logic signed      [31:0] high_o    // First coordinate above
);
  localparam logic [31:0] SPR = 32'(STEPS_PER_REV);
  // Width in steps; a zero range would never settle, so fall back
  wire logic [63:0] span_full_w = {32'h0, range_i} * {32'h0, SPR};
  wire logic [63:0] span_div_w  = span_full_w / `MCW_TENTHS_DIV;
  wire logic [31:0] span_w = (span_div_w[31:0] == 32'h0) ? SPR : span_div_w[31:0];
  // Share of the window below home
  wire logic [63:0] below_full_w = {32'h0, span_w} * {32'h0, ratio_i};
  wire logic [63:0] below_w      = below_full_w / `MCW_RATIO_FULL;
  assign span_o = span_w;
  assign low_o  = offset_i - $signed(below_w[31:0]);
  assign high_o = low_o + $signed(span_w);
endmodule : mcw_window

// File: shared/mcw_cfg_if.sv
// Carrier between register file and coordinate core.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mcw_cfg_if;
  mcw_pkg::mcw_cfg_s cfg;       // Host-written settings
  logic [31:0]       step_cnt;  // Free-running step counter
  logic [31:0]       coord;     // Present wrapped coordinate
  logic [31:0]       status;    // Core state summary
  modport regs (output cfg, input step_cnt, input coord, input status);
  modport core (input cfg, output step_cnt, output coord, output status);
endinterface : mcw_cfg_if

// File: shared/mcw_params.svh
// Named constants for the multi-turn coordinate wrap block.
// Assumes inclusion by bare name from the design files.
`ifndef MCW_PARAMS_SVH
`define MCW_PARAMS_SVH
// ----------------------------------------------------------------
// Register indices, byte address is index times four
// ----------------------------------------------------------------
`define MCW_IDX_WRAP_EN  16'h41c7
`define MCW_IDX_RANGE    16'h41c9
`define MCW_IDX_RATIO    16'h41cb
`define MCW_IDX_OFFSET   16'h41cc
`define MCW_IDX_STEP_CNT 16'h4091
`define MCW_IDX_SRC_SEL  16'h47f2
`define MCW_IDX_COORD    16'h4100
`define MCW_IDX_STATUS   16'h4101
// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define MCW_RST_WRAP_EN  1'h0
`define MCW_RST_RANGE    32'h4650
`define MCW_RST_RATIO    32'h1388
`define MCW_RST_OFFSET   32'h0
`define MCW_RST_SRC      32'h0
`define MCW_SRC_MANUAL   32'h1
`define MCW_TURNS_SMALL  11'h384
`define MCW_TURNS_LARGE  11'h708
`define MCW_TENTHS_REV   32'ha
`define MCW_TENTHS_DIV   64'ha
`define MCW_RATIO_FULL   64'h2710
`define MCW_RATIO_HALF   32'h1388
`endif

// File: shared/mcw_pkg.sv
// Types shared by the coordinate wrap block.
// Assumes nothing beyond a SystemVerilog compiler.
package mcw_pkg;
  // ----------------------------------------------------------------
  // Core states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    mcw_idle = 3'h1,  // Control power off, no coordinate
    mcw_calc = 3'h2,  // Initial coordinate generation
    mcw_run  = 3'h4   // Coordinate valid
  } mcw_state_e;
  // Host configuration as held in the register file
  typedef struct packed {
    logic               wrap_en;
    logic [31:0]        range;
    logic [31:0]        ratio;
    logic signed [31:0] offset;
    logic [31:0]        src;
  } mcw_cfg_s;
endpackage : mcw_pkg

// File: tb/mcw_motor_model.sv
// Motor side model: emits step pulses with a direction level.
// Assumes the same clock as the block, pulses back to back.
`timescale 1ns/100ps
module mcw_motor_model (
  input  wire logic clk_i,  // Shared clock
  output logic      step_o, // One pulse per step
  output logic      dir_o   // High: forward
);
  initial begin
    step_o = 1'b0;
    dir_o  = 1'b1;
  end
  // Burst of n steps, driven just after each edge
  task automatic run(input int n, input logic fwd);
    repeat (n) begin
      @(posedge clk_i);
      step_o <= 1'b1;
      dir_o  <= fwd;
    end
    @(posedge clk_i);
    step_o <= 1'b0;
  endtask : run
endmodule : mcw_motor_model

// File: tb/tb_mcw_top.sv
// Bench for the coordinate wrap top: bus, power and step cases.
// Assumes the motor model drives steps; the bench owns power pins.
`timescale 1ns/100ps
module tb_mcw_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mp = 0, cp = 0, fs = 0;
  logic [17:0] adr = 0;
  logic [31:0] dat = 0, rdat, q, coord, cnt;
  logic ack, valid, stp, dr;
  int err_total = 0, checked = 0;
  typedef struct {logic w; logic [15:0] ix; logic [31:0] d; logic [31:0] e;} mcw_row_s;
  // Reads expect reset values, the last the written range; writes try the step counter, then set a manual wrap of one turn
  mcw_row_s rows[14] = '{'{0, 16'h41c7, 0, 0}, '{0, 16'h41c9, 0, 32'h4650},
    '{0, 16'h41cb, 0, 32'h1388}, '{0, 16'h41cc, 0, 0}, '{0, 16'h47f2, 0, 0},
    '{0, 16'h4091, 0, 0}, '{0, 16'h4000, 0, 0}, '{1, 16'h4091, 32'hffff, 0},
    '{0, 16'h4091, 0, 0}, '{1, 16'h47f2, 1, 0}, '{1, 16'h41c7, 1, 0},
    '{1, 16'h41c9, 32'ha, 0}, '{1, 16'h41cb, 32'h1388, 0}, '{0, 16'h41c9, 0, 32'ha}};
  always #10 clk_i = ~clk_i;
  mcw_top #(.STEPS_PER_REV(4)) u_mcw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .main_pwr_i(mp), .ctl_pwr_i(cp), .frame_small_i(fs),
    .step_i(stp), .dir_i(dr), .coord_o(coord), .coord_valid_o(valid), .step_count_o(cnt));
  mcw_motor_model u_mcw_motor_model (.clk_i(clk_i), .step_o(stp), .dir_o(dr));
  task print_verdict;
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Classic single cycle; held until ack is sampled, bounded wait
  task bus(input logic w, input logic [15:0] ix, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= {ix, 2'h0}; dat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    if (n >= 50) begin err_total++; print_verdict; end
  endtask : bus
  // Set supplies, let the sync settle, then with control power on wait for a coordinate
  task pwr(input logic m, input logic c);
    int n;
    @(posedge clk_i);
    mp <= m; cp <= c;
    repeat (8) @(posedge clk_i);
    for (n = 0; n < 50 && c && valid !== 1'b1; n++) @(posedge clk_i);
    if (n == 50) begin err_total++; print_verdict; end
    chk({31'h0, valid}, {31'h0, c});
  endtask : pwr
  // Steps, then compare coordinate and raw counter
  task mv(input int n, input logic f, input logic [31:0] ec, input logic [31:0] ek);
    u_mcw_motor_model.run(n, f);
    repeat (2) @(posedge clk_i);
    chk(coord, ec);
    chk(cnt, ek);
  endtask : mv
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].ix, rows[i].d, q);
      if (!rows[i].w) chk(q, rows[i].e);
    end
    $display("test registers done");
    pwr(1, 1);
    chk(coord, 0);
    bus(0, 16'h4101, 0, q);
    chk(q, 32'h7);
    mv(2, 1, 32'hffff_fffe, 32'h2);
    mv(3, 1, 32'h1, 32'h5);
    mv(6, 0, 32'hffff_ffff, 32'hffff_ffff);
    bus(0, 16'h4091, 0, q);
    chk(q, 32'hffff_ffff);
    bus(1, 16'h41c9, 32'h14, q);
    mv(4, 1, 32'hffff_ffff, 32'h3);
    $display("test wrap done");
    bus(1, 16'h47f2, 0, q);
    pwr(1, 0);
    pwr(1, 1);
    chk(coord, 32'h3);
    bus(0, 16'h4101, 0, q);
    chk(q & 32'h4, 32'h4);
    pwr(0, 0);
    pwr(1, 1);
    bus(0, 16'h4101, 0, q);
    chk(q & 32'h7, 32'h1);
    chk(coord, 32'h3);
    $display("test power done");
    // Small frame: reverse from turn zero lands on the 900-turn maximum
    fs <= 1;
    pwr(0, 0);
    pwr(1, 1);
    mv(4, 0, 32'hffff_ffff, 32'hffff_ffff);
    bus(0, 16'h4101, 0, q);
    chk(q, 32'h0384_0001);
    pwr(0, 0);
    pwr(1, 1);
    chk(coord, 32'h3);
    $display("test frame done");
    rst_i <= 1;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(cnt, 0);
    chk({31'h0, valid}, 0);
    $display("test reset done");
    print_verdict;
  end
endmodule : tb_mcw_top
